/* File: circ_addr_regs.svh */
// register offsets, field positions and reset values for circular addressing
`ifndef CIRC_ADDR_REGS_SVH
`define CIRC_ADDR_REGS_SVH
// printed offsets are register indexes; byte address is four times the index
`define IDX_MODE_CONTROL 16'h0046
`define IDX_X_START 16'h0048
`define IDX_X_END 16'h004A
`define IDX_Y_START 16'h004C
`define IDX_Y_END 16'h004E
`define IDX_STATUS 16'h0060
`define ADDR_OF(idx) ({(idx), 2'b00})
`define XSEL_LSB 0
`define YSEL_LSB 4
`define SEL_W 4
`define YEN_BIT 14
`define XEN_BIT 15
`define SEL_OFF 4'hF
`define RST_MODE_CONTROL 16'h0000
`define RST_START 16'h0000
`define RST_END 16'h0001
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* File: circ_addr_pkg.sv */
// types shared by the circular addressing modules
package circ_addr_pkg;
  typedef logic [15:0] addr_t;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_DATA = 2'b01
  } rd_state_t;
endpackage : circ_addr_pkg

/* File: agu_if.sv */
// one address generator request and its answer
`timescale 1ns/1ps
interface agu_if;
  logic req;
  logic [3:0] wreg;
  circ_addr_pkg::addr_t ptr;
  circ_addr_pkg::addr_t step;
  logic [3:0] sel;
  logic en;
  logic word_only;
  circ_addr_pkg::addr_t start;
  circ_addr_pkg::addr_t fin;
  circ_addr_pkg::addr_t addr;
  logic wrap;
  logic ack;
  modport core (output req, wreg, ptr, step, sel, en, word_only, start, fin,
                input addr, wrap, ack);
  modport unit (input req, wreg, ptr, step, sel, en, word_only, start, fin,
                output addr, wrap, ack);
endinterface : agu_if

/* File: circ_wrap_unit.sv */
// one pointer update with circular wrap at the buffer boundaries
`timescale 1ns/1ps
`include "circ_addr_regs.svh"
module circ_wrap_unit (
  input wire logic clk,
  input wire logic resetn,
  agu_if.unit a
);
  logic active;
  logic over;
  logic under;
  logic [17:0] sum;
  circ_addr_pkg::addr_t result;
  circ_addr_pkg::addr_t next_addr;
  logic next_wrap;

  always_comb begin
    // any working register except 15 may be the selected pointer
    active = a.en && (a.sel != `SEL_OFF) && (a.wreg == a.sel); // R4 R10 R11 R12 R13
    sum = {2'b00, a.ptr} + {{2{a.step[15]}}, a.step};
    // end bound checked on non-negative steps, start bound on negative steps, so power-of-two buffers run either way
    over = !a.step[15] && (sum > {2'b00, a.fin}); // R6 R5
    under = a.step[15] && ($signed(sum) < $signed({2'b00, a.start})); // R6 R5
    result = sum[15:0];
    next_wrap = 1'b0;
    if (active) begin
      if (over) begin
        result = a.start; // R14 R1
        next_wrap = 1'b1;
      end else if (under) begin
        result = a.fin; // R14 R1
        next_wrap = 1'b1;
      end
      if (a.word_only) begin
        result[0] = 1'b0; // R8
      end
    end
    next_addr = a.req ? result : a.addr;
    if (!a.req) begin
      next_wrap = a.wrap;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      a.addr <= '0;
      a.wrap <= 1'b0;
      a.ack <= 1'b0;
    end else begin
      a.addr <= next_addr;
      a.wrap <= next_wrap;
      a.ack <= a.req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_upper_wrap_start: assert property (@(posedge clk) disable iff (!resetn) // R14
    a.req && active && over && !a.word_only |=> a.addr == $past(a.start) && a.wrap)
    else $error("pointer past end did not reload start");
  chk_lower_wrap_end: assert property (@(posedge clk) disable iff (!resetn) // R14
    a.req && active && under |=> a.wrap && a.addr[15:1] == $past(a.fin[15:1]))
    else $error("pointer below start did not reload end");
  chk_disabled_no_wrap: assert property (@(posedge clk) disable iff (!resetn) // R10
    a.req && (a.sel == `SEL_OFF || !a.en) |=> !a.wrap && a.addr == $past(sum[15:0]))
    else $error("wrap seen while circular addressing is off");
  chk_word_lsb_clear: assert property (@(posedge clk) disable iff (!resetn) // R8
    a.req && active && a.word_only |=> a.addr[0] == 1'b0)
    else $error("word-only address has bit 0 set");
  cov_upper_wrap: cover property (@(posedge clk) a.req && active && over);
  cov_lower_wrap: cover property (@(posedge clk) a.req && active && under);
endmodule : circ_wrap_unit

/* File: circ_addr_top.sv */
// circular buffer address wrap for X read, X write and Y generators
// What this block does
// R1: buffer wrap-around is done in hardware, no software bounds checks
// R2: X read generator also serves program-space reads through the same pointer
// R3: exactly one X-space buffer and one Y-space buffer
// R4: any working register may be the pointer; stack registers are discouraged (here select 15 turns wrap off, so register 15 cannot be the pointer)
// R5: software uses non-power-of-two buffers in one direction only
// R6: both boundaries are checked, so power-of-two buffers move either way
// R7: start and end addresses live in 16-bit registers per space
// R8: Y circular addresses treat bit 0 as zero, word data only
// R9: length follows from start and end; at most 32K words
// R10: X select of 15 disables wrap in X read and write generators
// R11: Y select of 15 disables wrap in the Y generator
// R12: X select in control bits 3..0; active only with enable bit 15
// R13: Y select in control bits 7..4; active only with enable bit 14
// R14: past end reloads start; below start reloads end
// R15: start bit 0 reads zero, end bit 0 one; control resets to zero
`timescale 1ns/1ps
`include "circ_addr_regs.svh"
module circ_addr_top (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // axi4-lite write address
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [17:0] AWADDR_I,
  input wire logic [2:0] AWPROT_I,
  // axi4-lite write data
  input wire logic WVALID_I,
  output logic WREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  // axi4-lite write response
  output logic BVALID_O,
  input wire logic BREADY_I,
  output logic [1:0] BRESP_O,
  // axi4-lite read address
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  input wire logic [17:0] ARADDR_I,
  input wire logic [2:0] ARPROT_I,
  // axi4-lite read data
  output logic RVALID_O,
  input wire logic RREADY_I,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  // x read generator, also program space
  input wire logic XR_REQ_I,
  input wire logic [3:0] XR_REG_I,
  input wire logic [15:0] XR_PTR_I,
  input wire logic [15:0] XR_STEP_I,
  output logic [15:0] XR_ADDR_O,
  output logic XR_WRAP_O,
  output logic XR_ACK_O,
  // x write generator
  input wire logic XW_REQ_I,
  input wire logic [3:0] XW_REG_I,
  input wire logic [15:0] XW_PTR_I,
  input wire logic [15:0] XW_STEP_I,
  output logic [15:0] XW_ADDR_O,
  output logic XW_WRAP_O,
  output logic XW_ACK_O,
  // y generator
  input wire logic Y_REQ_I,
  input wire logic [3:0] Y_REG_I,
  input wire logic [15:0] Y_PTR_I,
  input wire logic [15:0] Y_STEP_I,
  output logic [15:0] Y_ADDR_O,
  output logic Y_WRAP_O,
  output logic Y_ACK_O
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] mode_control;
  circ_addr_pkg::addr_t x_buffer_start;
  circ_addr_pkg::addr_t x_buffer_end;
  circ_addr_pkg::addr_t y_buffer_start;
  circ_addr_pkg::addr_t y_buffer_end;
  logic [15:0] next_mode_control;
  circ_addr_pkg::addr_t next_x_buffer_start;
  circ_addr_pkg::addr_t next_x_buffer_end;
  circ_addr_pkg::addr_t next_y_buffer_start;
  circ_addr_pkg::addr_t next_y_buffer_end;
  logic [3:0] x_pointer_select;
  logic [3:0] y_pointer_select;
  logic x_circular_enable;
  logic y_circular_enable;
  logic [2:0] wrap_seen;
  logic [2:0] next_wrap_seen;

  ////////////////////////////////////////////////////////////////////////////
  // write channel state
  circ_addr_pkg::wr_state_t wr_state;
  circ_addr_pkg::wr_state_t next_wr_state;
  logic aw_held;
  logic w_held;
  logic next_aw_held;
  logic next_w_held;
  logic [17:0] aw_addr;
  logic [17:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic do_write;
  logic [15:0] wr_val;
  logic wr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // read channel state
  circ_addr_pkg::rd_state_t rd_state;
  circ_addr_pkg::rd_state_t next_rd_state;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic [15:0] rd_val;
  logic rd_hit;

  assign x_pointer_select = mode_control[`XSEL_LSB +: `SEL_W]; // R12
  assign y_pointer_select = mode_control[`YSEL_LSB +: `SEL_W]; // R13
  assign x_circular_enable = mode_control[`XEN_BIT]; // R12
  assign y_circular_enable = mode_control[`YEN_BIT]; // R13

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data taken in either order, answer after both
  assign AWREADY_O = (wr_state == circ_addr_pkg::WR_IDLE) && !aw_held;
  assign WREADY_O = (wr_state == circ_addr_pkg::WR_IDLE) && !w_held;
  assign BVALID_O = (wr_state == circ_addr_pkg::WR_RESP);
  assign BRESP_O = bresp;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_wr_state = wr_state;
    do_write = 1'b0;
    case (wr_state)
      circ_addr_pkg::WR_IDLE: begin
        if (AWVALID_I && AWREADY_O) begin
          next_aw_held = 1'b1;
          next_aw_addr = AWADDR_I;
        end
        if (WVALID_I && WREADY_O) begin
          next_w_held = 1'b1;
          next_w_data = WDATA_I;
          next_w_strb = WSTRB_I;
        end
        if (next_aw_held && next_w_held) begin
          do_write = 1'b1;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_wr_state = circ_addr_pkg::WR_RESP;
        end
      end
      circ_addr_pkg::WR_RESP: begin
        if (BREADY_I) begin
          next_wr_state = circ_addr_pkg::WR_IDLE;
        end
      end
      default: begin
        next_wr_state = circ_addr_pkg::WR_IDLE;
      end
    endcase
  end

  // register decode of the completed write; sub-word lanes merge by strobe
  always_comb begin
    wr_hit = 1'b1;
    wr_val = 16'h0000;
    case (next_aw_addr[17:2])
      `IDX_MODE_CONTROL: wr_val = mode_control;
      `IDX_X_START: wr_val = x_buffer_start;
      `IDX_X_END: wr_val = x_buffer_end;
      `IDX_Y_START: wr_val = y_buffer_start;
      `IDX_Y_END: wr_val = y_buffer_end;
      `IDX_STATUS: wr_val = 16'h0000;
      default: wr_hit = 1'b0;
    endcase
    if (next_w_strb[0]) begin
      wr_val[7:0] = next_w_data[7:0];
    end
    if (next_w_strb[1]) begin
      wr_val[15:8] = next_w_data[15:8];
    end
    next_bresp = bresp;
    next_mode_control = mode_control;
    next_x_buffer_start = x_buffer_start;
    next_x_buffer_end = x_buffer_end;
    next_y_buffer_start = y_buffer_start;
    next_y_buffer_end = y_buffer_end;
    if (do_write) begin
      next_bresp = (wr_hit && next_aw_addr[1:0] == 2'b00) ? `RESP_OKAY : `RESP_SLVERR;
      if (next_aw_addr[1:0] == 2'b00) begin
        case (next_aw_addr[17:2])
          `IDX_MODE_CONTROL: next_mode_control = wr_val;
          `IDX_X_START: next_x_buffer_start = {wr_val[15:1], 1'b0}; // R15 R7
          `IDX_X_END: next_x_buffer_end = {wr_val[15:1], 1'b1}; // R15 R7
          `IDX_Y_START: next_y_buffer_start = {wr_val[15:1], 1'b0}; // R15 R7
          `IDX_Y_END: next_y_buffer_end = {wr_val[15:1], 1'b1}; // R15 R7
          default: next_mode_control = mode_control;
        endcase
      end
    end
  end

  // sticky wrap flags; a wrap in the clearing cycle survives the clear
  always_comb begin
    next_wrap_seen = wrap_seen;
    if (do_write && next_aw_addr[17:2] == `IDX_STATUS && next_w_strb[0]) begin
      next_wrap_seen = wrap_seen & ~next_w_data[2:0];
    end
    next_wrap_seen = next_wrap_seen | {Y_WRAP_O & Y_ACK_O, XW_WRAP_O & XW_ACK_O,
                                       XR_WRAP_O & XR_ACK_O};
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      wr_state <= circ_addr_pkg::WR_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bresp <= `RESP_OKAY;
      mode_control <= `RST_MODE_CONTROL; // R15
      x_buffer_start <= `RST_START;
      x_buffer_end <= `RST_END;
      y_buffer_start <= `RST_START;
      y_buffer_end <= `RST_END;
      wrap_seen <= 3'b000;
    end else begin
      wr_state <= next_wr_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bresp <= next_bresp;
      mode_control <= next_mode_control;
      x_buffer_start <= next_x_buffer_start;
      x_buffer_end <= next_x_buffer_end;
      y_buffer_start <= next_y_buffer_start;
      y_buffer_end <= next_y_buffer_end;
      wrap_seen <= next_wrap_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read: one cycle from address to data
  assign ARREADY_O = (rd_state == circ_addr_pkg::RD_IDLE);
  assign RVALID_O = (rd_state == circ_addr_pkg::RD_DATA);
  assign RDATA_O = rdata;
  assign RRESP_O = rresp;

  always_comb begin
    rd_hit = 1'b1;
    case (ARADDR_I[17:2])
      `IDX_MODE_CONTROL: rd_val = mode_control;
      `IDX_X_START: rd_val = x_buffer_start;
      `IDX_X_END: rd_val = x_buffer_end;
      `IDX_Y_START: rd_val = y_buffer_start;
      `IDX_Y_END: rd_val = y_buffer_end;
      `IDX_STATUS: rd_val = {11'h000, 1'b1, 1'b0, wrap_seen};
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
    next_rd_state = rd_state;
    next_rdata = rdata;
    next_rresp = rresp;
    case (rd_state)
      circ_addr_pkg::RD_IDLE: begin
        if (ARVALID_I) begin
          next_rd_state = circ_addr_pkg::RD_DATA;
          next_rdata = {16'h0000, rd_val};
          next_rresp = (rd_hit && ARADDR_I[1:0] == 2'b00) ? `RESP_OKAY : `RESP_SLVERR;
        end
      end
      circ_addr_pkg::RD_DATA: begin
        if (RREADY_I) begin
          next_rd_state = circ_addr_pkg::RD_IDLE;
        end
      end
      default: begin
        next_rd_state = circ_addr_pkg::RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rd_state <= circ_addr_pkg::RD_IDLE;
      rdata <= '0;
      rresp <= `RESP_OKAY;
    end else begin
      rd_state <= next_rd_state;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // generators: x read and x write share the x buffer, y has its own
  agu_if uxr ();
  agu_if uxw ();
  agu_if ux ();

  // x read generator also carries program-space reads
  assign uxr.req = XR_REQ_I; // R2
  assign uxr.wreg = XR_REG_I;
  assign uxr.ptr = XR_PTR_I;
  assign uxr.step = XR_STEP_I;
  assign uxr.sel = x_pointer_select; // R10
  assign uxr.en = x_circular_enable;
  assign uxr.word_only = 1'b0;
  assign uxr.start = x_buffer_start; // R3
  assign uxr.fin = x_buffer_end;

  assign uxw.req = XW_REQ_I;
  assign uxw.wreg = XW_REG_I;
  assign uxw.ptr = XW_PTR_I;
  assign uxw.step = XW_STEP_I;
  assign uxw.sel = x_pointer_select; // R10
  assign uxw.en = x_circular_enable;
  assign uxw.word_only = 1'b0;
  assign uxw.start = x_buffer_start; // R3
  assign uxw.fin = x_buffer_end;

  assign ux.req = Y_REQ_I;
  assign ux.wreg = Y_REG_I;
  assign ux.ptr = Y_PTR_I;
  assign ux.step = Y_STEP_I;
  assign ux.sel = y_pointer_select; // R11
  assign ux.en = y_circular_enable;
  assign ux.word_only = 1'b1; // R8
  assign ux.start = y_buffer_start; // R3
  assign ux.fin = y_buffer_end;

  // length is end minus start plus one; 16-bit span caps it at 32K words
  circ_wrap_unit u_xr (.clk(CLK_I), .resetn(RESETN_I), .a(uxr)); // R9
  circ_wrap_unit u_xw (.clk(CLK_I), .resetn(RESETN_I), .a(uxw));
  circ_wrap_unit u_y (.clk(CLK_I), .resetn(RESETN_I), .a(ux));

  assign XR_ADDR_O = uxr.addr;
  assign XR_WRAP_O = uxr.wrap;
  assign XR_ACK_O = uxr.ack;
  assign XW_ADDR_O = uxw.addr;
  assign XW_WRAP_O = uxw.wrap;
  assign XW_ACK_O = uxw.ack;
  assign Y_ADDR_O = ux.addr;
  assign Y_WRAP_O = ux.wrap;
  assign Y_ACK_O = ux.ack;

  ////////////////////////////////////////////////////////////////////////////
  chk_start_lsb_zero: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R15
    x_buffer_start[0] == 1'b0 && y_buffer_start[0] == 1'b0)
    else $error("start register bit 0 not zero");
  chk_end_lsb_one: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R15
    $rose(BVALID_O) && BRESP_O == `RESP_OKAY |-> x_buffer_end[0] && y_buffer_end[0])
    else $error("end register bit 0 not one");
  chk_ctrl_reset_zero: assert property (@(posedge CLK_I) // R15
    !RESETN_I |=> mode_control == 16'h0000)
    else $error("control not cleared by reset");
  chk_y_off_by_sel: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R11
    Y_REQ_I && y_pointer_select == `SEL_OFF |=> !Y_WRAP_O)
    else $error("y wrapped with select 15");
  chk_x_needs_enable: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R12
    XR_REQ_I && !x_circular_enable |=> !XR_WRAP_O)
    else $error("x wrapped without enable");
  chk_ack_follows_req: assert property (@(posedge CLK_I) disable iff (!RESETN_I) // R1
    Y_REQ_I |=> Y_ACK_O)
    else $error("y request not answered next cycle");
  cov_write_both: cover property (@(posedge CLK_I) AWVALID_I && WVALID_I && AWREADY_O);
  cov_read_status: cover property (@(posedge CLK_I) RVALID_O && RREADY_I);
endmodule : circ_addr_top

/* File: core_agent.sv */
// model of the core datapath that asks one address generator for pointer updates
`timescale 1ns/1ps
module core_agent (
  // clock
  input wire logic clk_i,
  // request side
  output logic req_o,
  output logic [3:0] reg_o,
  output logic [15:0] ptr_o,
  output logic [15:0] step_o,
  // answer side
  input wire logic [15:0] addr_i,
  input wire logic wrap_i,
  input wire logic ack_i
);
  initial begin
    req_o = 1'b0;
    reg_o = 4'hF;
    ptr_o = 16'h0000;
    step_o = 16'h0000;
  end

  // one-cycle request, answer sampled once the next edge has landed
  task automatic update(input logic [3:0] r, input logic [15:0] p, input logic [15:0] s,
                        output logic [17:0] res);
    @(posedge clk_i);
    req_o <= 1'b1;
    reg_o <= r;
    ptr_o <= p;
    step_o <= s;
    @(posedge clk_i);
    req_o <= 1'b0;
    // operands are stale once taken, so show something else
    ptr_o <= ~p;
    step_o <= ~s;
    #1;
    res = {ack_i, wrap_i, addr_i};
  endtask : update
endmodule : core_agent

/* File: testbench.sv */
// self-checking bench for circular buffer address wrap
`timescale 1ns/1ps
`include "circ_addr_regs.svh"
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [17:0] awaddr = 18'h0_0000, araddr = 18'h0_0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] xr_reg, xw_reg, y_reg;
  logic [15:0] xr_ptr, xr_step, xr_addr, xw_ptr, xw_step, xw_addr, y_ptr, y_step, y_addr;
  logic xr_req, xr_wrap, xr_ack, xw_req, xw_wrap, xw_ack, y_req, y_wrap, y_ack;
  int bad_count = 0;
  int n_compared = 0;

  always #2.5 clk = ~clk;

  circ_addr_top dut (.CLK_I(clk), .RESETN_I(rst_n),
    .AWVALID_I(awvalid), .AWREADY_O(awready), .AWADDR_I(awaddr), .AWPROT_I(3'b000),
    .WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(wstrb),
    .BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp),
    .ARVALID_I(arvalid), .ARREADY_O(arready), .ARADDR_I(araddr), .ARPROT_I(3'b000),
    .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
    .XR_REQ_I(xr_req), .XR_REG_I(xr_reg), .XR_PTR_I(xr_ptr), .XR_STEP_I(xr_step),
    .XR_ADDR_O(xr_addr), .XR_WRAP_O(xr_wrap), .XR_ACK_O(xr_ack),
    .XW_REQ_I(xw_req), .XW_REG_I(xw_reg), .XW_PTR_I(xw_ptr), .XW_STEP_I(xw_step),
    .XW_ADDR_O(xw_addr), .XW_WRAP_O(xw_wrap), .XW_ACK_O(xw_ack),
    .Y_REQ_I(y_req), .Y_REG_I(y_reg), .Y_PTR_I(y_ptr), .Y_STEP_I(y_step),
    .Y_ADDR_O(y_addr), .Y_WRAP_O(y_wrap), .Y_ACK_O(y_ack));

  core_agent x_rd (.clk_i(clk), .req_o(xr_req), .reg_o(xr_reg), .ptr_o(xr_ptr),
    .step_o(xr_step), .addr_i(xr_addr), .wrap_i(xr_wrap), .ack_i(xr_ack));
  core_agent x_wr (.clk_i(clk), .req_o(xw_req), .reg_o(xw_reg), .ptr_o(xw_ptr),
    .step_o(xw_step), .addr_i(xw_addr), .wrap_i(xw_wrap), .ack_i(xw_ack));
  core_agent y_gen (.clk_i(clk), .req_o(y_req), .reg_o(y_reg), .ptr_o(y_ptr),
    .step_o(y_step), .addr_i(y_addr), .wrap_i(y_wrap), .ack_i(y_ack));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // ready is read at the falling edge, so it is the value the next rising edge samples
  task automatic axi_write(input logic [17:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    logic aw_go, w_go, b_go;
    n = 0;
    b_go = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_go && n < 50) begin
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_go = bvalid;
      resp = bresp;
      n++;
      @(posedge clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b_go) check(32'h0000_0000, 32'h0000_0001);
  endtask : axi_write

  task automatic axi_read(input logic [17:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic ar_go, r_go;
    n = 0;
    r_go = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_go && n < 50) begin
      @(negedge clk);
      ar_go = arvalid && arready;
      r_go = rvalid;
      d = rdata;
      resp = rresp;
      n++;
      @(posedge clk);
      if (ar_go) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!r_go) check(32'h0000_0000, 32'h0000_0002);
  endtask : axi_read

  task automatic reg_chk(input logic [17:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check({d[31:2], r}, {exp[31:2], `RESP_OKAY});
    check(d, exp);
  endtask : reg_chk

  task automatic reg_wr(input logic [17:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask : reg_wr

  // g selects the generator: 0 x read, 1 x write, 2 y
  task automatic gen_chk(input int g, input logic [3:0] r, input logic [15:0] p,
                         input logic [15:0] s, input logic [15:0] ea, input logic ew);
    logic [17:0] res;
    case (g)
      0: x_rd.update(r, p, s, res);
      1: x_wr.update(r, p, s, res);
      default: y_gen.update(r, p, s, res);
    endcase
    check({14'h0, res}, {14'h0, 1'b1, ew, ea});
  endtask : gen_chk

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    reg_chk(`ADDR_OF(`IDX_MODE_CONTROL), 32'h0000_0000);
    reg_chk(`ADDR_OF(`IDX_X_START), 32'h0000_0000);
    reg_chk(`ADDR_OF(`IDX_X_END), 32'h0000_0001);
    reg_chk(`ADDR_OF(`IDX_Y_START), 32'h0000_0000);
    reg_chk(`ADDR_OF(`IDX_Y_END), 32'h0000_0001);
    axi_read(18'h0_0004, d, r);
    check({d[31:2], r}, {30'h0, `RESP_SLVERR});
    $display("test reset values done");
  endtask : t_reset

  task automatic t_regs;
    logic [1:0] r;
    reg_wr(`ADDR_OF(`IDX_X_START), 32'h0000_1001);
    reg_wr(`ADDR_OF(`IDX_X_END), 32'h0000_100E);
    reg_wr(`ADDR_OF(`IDX_Y_START), 32'h0000_2001);
    reg_wr(`ADDR_OF(`IDX_Y_END), 32'h0000_201E);
    reg_wr(`ADDR_OF(`IDX_MODE_CONTROL), 32'h0000_80F3);
    reg_chk(`ADDR_OF(`IDX_X_START), 32'h0000_1000);
    reg_chk(`ADDR_OF(`IDX_X_END), 32'h0000_100F);
    reg_chk(`ADDR_OF(`IDX_Y_START), 32'h0000_2000);
    reg_chk(`ADDR_OF(`IDX_Y_END), 32'h0000_201F);
    reg_chk(`ADDR_OF(`IDX_MODE_CONTROL), 32'h0000_80F3);
    axi_write(18'h0_0008, 32'h0000_FFFF, r);
    check({30'h0, r}, {30'h0, `RESP_SLVERR});
    $display("test register access done");
  endtask : t_regs

  // buffers here are power-of-two long, so stepping either way is legal
  task automatic t_xwrap;
    for (int g = 0; g < 2; g++) begin
      gen_chk(g, 4'h3, 16'h100E, 16'h0002, 16'h1000, 1'b1);
      gen_chk(g, 4'h3, 16'h1000, 16'hFFFE, 16'h100F, 1'b1);
      gen_chk(g, 4'h3, 16'h1004, 16'h0002, 16'h1006, 1'b0);
      gen_chk(g, 4'h4, 16'h100E, 16'h0002, 16'h1010, 1'b0);
    end
    gen_chk(0, 4'h3, 16'h100C, 16'h0004, 16'h1000, 1'b1);
    reg_wr(`ADDR_OF(`IDX_X_END), 32'h0000_1007);
    gen_chk(0, 4'h3, 16'h1006, 16'h0002, 16'h1000, 1'b1);
    reg_wr(`ADDR_OF(`IDX_X_END), 32'h0000_100F);
    $display("test x wrap done");
  endtask : t_xwrap

  task automatic t_xoff;
    reg_wr(`ADDR_OF(`IDX_MODE_CONTROL), 32'h0000_80FF);
    gen_chk(0, 4'hF, 16'h100E, 16'h0002, 16'h1010, 1'b0);
    gen_chk(1, 4'hF, 16'h100E, 16'h0002, 16'h1010, 1'b0);
    reg_wr(`ADDR_OF(`IDX_MODE_CONTROL), 32'h0000_00F3);
    gen_chk(0, 4'h3, 16'h100E, 16'h0002, 16'h1010, 1'b0);
    $display("test x disable done");
  endtask : t_xoff

  task automatic t_y;
    reg_wr(`ADDR_OF(`IDX_MODE_CONTROL), 32'h0000_403F);
    gen_chk(2, 4'h3, 16'h201E, 16'h0002, 16'h2000, 1'b1);
    gen_chk(2, 4'h3, 16'h2000, 16'hFFFE, 16'h201E, 1'b1);
    gen_chk(2, 4'h3, 16'h2004, 16'h0003, 16'h2006, 1'b0);
    gen_chk(0, 4'h3, 16'h100E, 16'h0002, 16'h1010, 1'b0);
    reg_wr(`ADDR_OF(`IDX_MODE_CONTROL), 32'h0000_40FF);
    gen_chk(2, 4'hF, 16'h201E, 16'h0002, 16'h2020, 1'b0);
    reg_wr(`ADDR_OF(`IDX_MODE_CONTROL), 32'h0000_003F);
    gen_chk(2, 4'h3, 16'h201E, 16'h0002, 16'h2020, 1'b0);
    $display("test y wrap done");
  endtask : t_y

  // every generator has wrapped by now; status bit 4 always reads one
  task automatic t_status;
    reg_chk(`ADDR_OF(`IDX_STATUS), 32'h0000_0017);
    reg_wr(`ADDR_OF(`IDX_STATUS), 32'h0000_0007);
    reg_chk(`ADDR_OF(`IDX_STATUS), 32'h0000_0010);
    $display("test wrap status done");
  endtask : t_status

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_xwrap();
    t_xoff();
    t_y();
    t_status();
    close_out();
  end

  // whole run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule : testbench
